// ### verilog/snf_cmd_flags.v
// snf_cmd_flags.v: serial flash command decoder and operation flags.
// assumes serial pins arrive unsynchronised; the array controller runs
// on ref_clk and reports busy, suspend and failure events to this block.
`timescale 1ns/100ps
`default_nettype none
`include "snf_regs.vh"
module snf_cmd_flags #(
  parameter [23:0] ID_BYTES = 24'h5a3c11  // arbitrary identity bytes
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        sclk,
  input  wire        cs_n,
  input  wire [3:0]  dq_in,
  output reg  [3:0]  dq_out_ff,
  output reg  [3:0]  dq_oe_ff,
  input  wire [3:0]  dummy_clks,
  input  wire        pe_busy,
  input  wire        erase_susp,
  input  wire        prog_susp,
  input  wire        evt_erase_fail,
  input  wire        evt_prog_fail,
  input  wire        evt_vpp_bad,
  input  wire        evt_prot_fail,
  input  wire [7:0]  arr_rdata,
  output reg         arr_rd_stb_ff,
  output reg         op_go_ff,
  output reg  [7:0]  op_code_ff,
  output reg  [31:0] op_addr_ff,
  output reg  [7:0]  prog_byte_ff,
  output reg         prog_stb_ff,
  output wire [7:0]  operation_flags
);
  // one-hot command phases
  localparam [5:0] ST_OPC = 6'h01;
  localparam [5:0] ST_ADR = 6'h02;
  localparam [5:0] ST_DMY = 6'h04;
  localparam [5:0] ST_OUT = 6'h08;
  localparam [5:0] ST_IN  = 6'h10;
  localparam [5:0] ST_IGN = 6'h20;
  // decode result fields
  localparam D_OK = 0;
  localparam D_ADR = 1;
  localparam D_DMY = 2;
  localparam D_OUT = 3;
  localparam D_WEL = 4;
  localparam D_A4 = 5;

  // lane code to bits per clock: 0 single, 1 dual, 2 quad
  function [3:0] lw;
    input [1:0] l;
    begin
      lw = (l == 2'd2) ? 4'd4 : (l == 2'd1) ? 4'd2 : 4'd1;
    end
  endfunction

  // shift incoming lanes into a byte, msb first
  function [7:0] sh_in;
    input [7:0] s;
    input [3:0] d;
    input [1:0] l;
    begin
      case (l)
        2'd1:    sh_in = {s[5:0], d[1:0]};
        2'd2:    sh_in = {s[3:0], d};
        default: sh_in = {s[6:0], d[0]};
      endcase
    end
  endfunction

  // wider of protocol lanes and command lanes
  function [1:0] lmax;
    input [1:0] a;
    input [1:0] b;
    begin
      lmax = (a > b) ? a : b;
    end
  endfunction

  // opcode decode: {addr lanes[10:9], data lanes[8:7], spare, a4, wel,
  // out, dmy, adr, ok}; lane codes as in lw, widened later by protocol
  function [10:0] dec;
    input [7:0] op;
    input [1:0] p;
    reg ex;
    reg du;
    reg qu;
    begin
      ex = (p == 2'd0);
      du = (p == 2'd1);
      qu = (p == 2'd2);
      dec = 11'h000;
      case (op)
        // flag read; status read; evc read; segment read
        8'h70, 8'h05, 8'h65, 8'hc8: dec = 11'h009;
        8'h50, 8'h06, 8'h04, 8'hb7, 8'he9, 8'h75, 8'h7a:
          dec = 11'h001;
        8'h01, 8'h61, 8'hc5: dec = 11'h011;
        8'h9e, 8'h9f: dec = {10'h004, ex};
        8'haf:        dec = {10'h004, ~ex};
        8'h03:        dec = {10'h005, ex};
        // fast reads; lanes widen with protocol
        8'h0b, 8'h0d: dec = 11'h00f;
        8'h3b, 8'h3d: dec = {10'h047, ex | du};
        8'hbb, 8'hbd: dec = {10'h147, ex | du};
        8'h6b, 8'h6d: dec = {10'h087, ex | qu};
        8'heb, 8'hed: dec = {10'h287, ex | qu};
        8'h13:        dec = 11'h02b;
        8'h0c:        dec = 11'h02f;
        8'h3c:        dec = {10'h057, ex | du};
        8'hbc:        dec = {10'h157, ex | du};
        8'h6c:        dec = {10'h097, ex | qu};
        8'hec:        dec = {10'h297, ex | qu};
        8'h02:        dec = 11'h013;
        8'ha2:        dec = {10'h049, ex | du};
        8'hd2:        dec = {10'h149, ex | du};
        8'h32:        dec = {10'h089, ex | qu};
        8'h34:        dec = {10'h099, ex | qu};
        8'h20:        dec = 11'h013;
        8'h21:        dec = 11'h033;
        default:      dec = 11'h000;
      endcase
    end
  endfunction

  // three-stage pin synchronisers: sclk, cs_n, dq
  reg  [5:0]  sy1_ff;             // first stage, read only by second
  reg  [5:0]  sy2_ff;             // second stage
  reg  [5:0]  sy3_ff;             // third stage
  reg  [5:0]  pin_ff;             // filtered pin levels
  reg         sclk_d_ff;          // previous filtered sclk
  reg         cs_d_ff;            // previous filtered cs_n
  // command state
  reg  [5:0]  st_ff;
  reg  [7:0]  sh_ff;              // opcode / data byte shifter
  reg  [7:0]  op_ff;              // latched opcode
  reg  [10:0] dec_ff;             // latched decode of op_ff
  reg  [5:0]  bit_ff;             // bits taken in this phase
  reg  [3:0]  dmy_ff;             // dummy clocks taken
  reg  [8:0]  nb_ff;              // data bytes in or out
  reg  [7:0]  wbyte_ff;           // first data byte of a write
  reg  [7:0]  osh_ff;             // output shifter
  reg  [3:0]  ocnt_ff;            // bits left in output shifter
  reg  [31:0] adr_ff;             // address shifter
  // registers kept here
  reg  [7:0]  evc_ff;             // enhanced volatile configuration
  reg  [7:0]  stat_ff;            // main status, upper bits
  reg         seg_ff;             // segment extension bit
  reg         wel_ff;             // write enable latch
  reg         adr4_ff;            // four-byte address mode
  reg         e_erase_ff;
  reg         e_prog_ff;
  reg         e_vpp_ff;
  reg         e_prot_ff;

  wire [5:0] pin_chg = sy2_ff ^ sy3_ff;      // stages disagree
  wire       sclk_f  = pin_ff[0];
  wire       cs_f    = pin_ff[1];
  wire [3:0] dq_f    = pin_ff[5:2];
  wire       rise    = sclk_f & ~sclk_d_ff & ~cs_f;
  wire       fall    = ~sclk_f & sclk_d_ff & ~cs_f;
  wire       desel   = cs_f & ~cs_d_ff;
  // protocol: 0 extended, 1 dual, 2 quad
  wire [1:0] proto = ~evc_ff[`SNF_EVC_QUAD] ? 2'd2 :
                     ~evc_ff[`SNF_EVC_DUAL] ? 2'd1 : 2'd0;
  wire [7:0]  sh_nxt = sh_in(sh_ff, dq_f, proto);
  wire [10:0] dec_nxt = dec(sh_nxt, proto);
  wire [1:0]  dln = lmax(proto, dec_ff[8:7]);  // data lanes
  wire [1:0]  aln = lmax(proto, dec_ff[10:9]); // address lanes
  wire [3:0]  dw = lw(dln);
  wire [3:0]  aw = lw(aln);
  wire        a4 = adr4_ff | dec_ff[D_A4];
  wire [5:0]  abits = a4 ? 6'd32 : 6'd24;
  // default dummy count, quad takes longer
  wire [3:0]  dmy_tgt = (dummy_clks != 4'h0) ? dummy_clks :
                        (proto == 2'd2) ? `SNF_DMY_QUAD : `SNF_DMY_DEF;
  wire        err_pend = e_erase_ff | e_prog_ff | e_prot_ff;
  wire [7:0]  din_nxt = sh_in(sh_ff, dq_f, dln);
  wire [5:0]  bit_in = bit_ff + {2'b00, dw};
  wire        is_prog = dec_ff[D_WEL] & dec_ff[D_ADR] &
                        (op_ff[7:4] != 4'h2);
  wire        is_pe = dec_ff[D_WEL] & dec_ff[D_ADR];
  wire        clr_cmd = desel & (st_ff == ST_IN) &
                        (op_ff == `SNF_OP_CLRFLAG);

  assign operation_flags = {~pe_busy, erase_susp, e_erase_ff, e_prog_ff,
                            e_vpp_ff, prog_susp, e_prot_ff, adr4_ff};

  // output byte selected at each byte boundary
  reg [7:0] obyte;
  always @* begin
    case (op_ff)
      `SNF_OP_RDFLAG: obyte = operation_flags;
      `SNF_OP_RDSTAT: obyte = {stat_ff[7:2], wel_ff, pe_busy};
      `SNF_OP_RDEVC:  obyte = evc_ff;
      `SNF_OP_RDSEG:  obyte = {7'h00, seg_ff};
      // id bytes, zeros beyond the table and the limit
      `SNF_OP_ID_A, `SNF_OP_ID_B, `SNF_OP_ID_MIO:
        obyte = (nb_ff == 9'd0) ? ID_BYTES[23:16] :
                (nb_ff == 9'd1) ? ID_BYTES[15:8]  :
                (nb_ff == 9'd2) ? ID_BYTES[7:0]   : 8'h00;
      default:        obyte = arr_rdata;
    endcase
  end

  // pin synchroniser and filter: a change counts once stages 2 and 3 agree
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sy1_ff    <= 6'h02;
      sy2_ff    <= 6'h02;
      sy3_ff    <= 6'h02;
      pin_ff    <= 6'h02;
      sclk_d_ff <= 1'b0;
      cs_d_ff   <= 1'b1;
    end else begin
      sy1_ff    <= {dq_in, cs_n, sclk};
      sy2_ff    <= sy1_ff;
      sy3_ff    <= sy2_ff;
      pin_ff    <= (sy3_ff & ~pin_chg) | (pin_ff & pin_chg);
      sclk_d_ff <= sclk_f;
      cs_d_ff   <= cs_f;
    end
  end

  // command phase sequencer, driven by sampled sclk edges
  always @(posedge ref_clk) begin
    if (!rst_n || cs_f) begin
      st_ff         <= ST_OPC;
      sh_ff         <= 8'h00;
      bit_ff        <= 6'd0;
      dmy_ff        <= 4'h0;
      nb_ff         <= 9'd0;
      ocnt_ff       <= 4'h0;
      osh_ff        <= 8'h00;
      dq_out_ff     <= 4'h0;
      dq_oe_ff      <= 4'h0;
      arr_rd_stb_ff <= 1'b0;
      prog_stb_ff   <= 1'b0;
      if (!rst_n) begin
        op_ff        <= 8'h00;
        dec_ff       <= 11'h000;
        adr_ff       <= 32'h0;
        wbyte_ff     <= 8'h00;
        prog_byte_ff <= 8'h00;
      end
    end else begin
      arr_rd_stb_ff <= 1'b0;
      prog_stb_ff   <= 1'b0;
      case (st_ff)
        // opcode arrives on the protocol's lanes
        ST_OPC: if (rise) begin
          sh_ff  <= sh_nxt;
          bit_ff <= bit_ff + {2'b00, lw(proto)};
          if (bit_ff + {2'b00, lw(proto)} == 6'd8) begin
            op_ff  <= sh_nxt;
            dec_ff <= dec_nxt;
            bit_ff <= 6'd0;
            if (!dec_nxt[D_OK])
              st_ff <= ST_IGN;
            else if (dec_nxt[D_ADR])
              st_ff <= ST_ADR;
            else if (dec_nxt[D_OUT])
              st_ff <= ST_OUT;
            else
              st_ff <= ST_IN;
          end
        end
        // address, three or four bytes
        ST_ADR: if (rise) begin
          case (aln)
            2'd1:    adr_ff <= {adr_ff[29:0], dq_f[1:0]};
            2'd2:    adr_ff <= {adr_ff[27:0], dq_f};
            default: adr_ff <= {adr_ff[30:0], dq_f[0]};
          endcase
          bit_ff <= bit_ff + {2'b00, aw};
          if (bit_ff + {2'b00, aw} == abits) begin
            bit_ff <= 6'd0;
            st_ff  <= dec_ff[D_DMY] ? ST_DMY :
                      dec_ff[D_OUT] ? ST_OUT : ST_IN;
          end
        end
        ST_DMY: if (rise) begin
          dmy_ff <= dmy_ff + 4'h1;
          if (dmy_ff + 4'h1 == dmy_tgt)
            st_ff <= ST_OUT;
        end
        ST_OUT: if (fall) begin
          dq_oe_ff <= (dln == 2'd2) ? 4'hf :
                      (dln == 2'd1) ? 4'h3 : 4'h2;
          if (ocnt_ff == 4'h0) begin
            osh_ff  <= obyte << dw;
            ocnt_ff <= 4'h8 - dw;
            nb_ff   <= (nb_ff == 9'h1ff) ? nb_ff : nb_ff + 9'd1;
            // register and id reads never touch the array
            arr_rd_stb_ff <= dec_ff[D_ADR] & ~dec_ff[D_WEL];
            case (dln)
              2'd1:    dq_out_ff <= {2'b00, obyte[7:6]};
              2'd2:    dq_out_ff <= obyte[7:4];
              default: dq_out_ff <= {2'b00, obyte[7], 1'b0};
            endcase
          end else begin
            osh_ff  <= osh_ff << dw;
            ocnt_ff <= ocnt_ff - dw;
            case (dln)
              2'd1:    dq_out_ff <= {2'b00, osh_ff[7:6]};
              2'd2:    dq_out_ff <= osh_ff[7:4];
              default: dq_out_ff <= {2'b00, osh_ff[7], 1'b0};
            endcase
          end
        end
        // data bytes in; program bytes forwarded when allowed
        ST_IN: if (rise) begin
          sh_ff  <= din_nxt;
          bit_ff <= bit_in;
          if (bit_in == 6'd8) begin
            bit_ff <= 6'd0;
            nb_ff  <= (nb_ff == 9'h1ff) ? nb_ff : nb_ff + 9'd1;
            if (nb_ff == 9'd0)
              wbyte_ff <= din_nxt;
            // up to 256 bytes, gated by latch and errors
            if (is_prog && nb_ff < `SNF_PROG_MAX && wel_ff && !err_pend) begin
              prog_byte_ff <= din_nxt;
              prog_stb_ff  <= 1'b1;
            end
          end
        end
        ST_IGN: st_ff <= ST_IGN;
        default: st_ff <= ST_OPC;
      endcase
    end
  end

  // register file and flags; commands act at deselect, error events set flags in any cycle
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      evc_ff     <= `SNF_RST_EVC;
      stat_ff    <= `SNF_RST_STAT;
      seg_ff     <= `SNF_RST_SEG;
      wel_ff     <= 1'b0;
      adr4_ff    <= 1'b0;
      e_erase_ff <= 1'b0;
      e_prog_ff  <= 1'b0;
      e_vpp_ff   <= `SNF_RST_SUPPLY;
      e_prot_ff  <= 1'b0;
      op_go_ff   <= 1'b0;
      op_code_ff <= 8'h00;
      op_addr_ff <= 32'h0;
    end else begin
      op_go_ff <= 1'b0;
      // clear first so a same-cycle event still sets
      if (clr_cmd) begin
        e_erase_ff <= 1'b0;
        e_prog_ff  <= 1'b0;
        e_vpp_ff   <= 1'b0;
        e_prot_ff  <= 1'b0;
      end
      if (desel && st_ff == ST_IN) begin
        case (op_ff)
          `SNF_OP_WREN:     wel_ff <= 1'b1;
          `SNF_OP_WRDI:     wel_ff <= 1'b0;
          `SNF_OP_ADR4_ON:  adr4_ff <= 1'b1;
          `SNF_OP_ADR4_OFF: adr4_ff <= 1'b0;
          `SNF_OP_SUSP, `SNF_OP_RESUME: begin
            op_go_ff   <= 1'b1;
            op_code_ff <= op_ff;
          end
          // evc takes exactly one byte, bit 5 fixed low
          `SNF_OP_WREVC: if (wel_ff && nb_ff == 9'd1) begin
            evc_ff <= wbyte_ff & ~(8'h01 << `SNF_EVC_FIXED0);
            wel_ff <= 1'b0;
          end
          // status write, low two bits are live state
          `SNF_OP_WRSTAT: if (wel_ff && nb_ff != 9'd0) begin
            stat_ff <= {wbyte_ff[7:2], 2'b00};
            wel_ff  <= 1'b0;
          end
          // segment write keeps bit 0 only
          `SNF_OP_WRSEG: if (wel_ff && nb_ff != 9'd0) begin
            seg_ff <= wbyte_ff[0];
            wel_ff <= 1'b0;
          end
          default: if (is_pe && wel_ff) begin
            wel_ff <= 1'b0;
            // pending error turns command into protection error
            if (err_pend)
              e_prot_ff <= 1'b1;
            else if (!is_prog || nb_ff != 9'd0) begin
              op_go_ff   <= 1'b1;
              op_code_ff <= op_ff;
              op_addr_ff <= a4 ? adr_ff : {7'h00, seg_ff, adr_ff[23:0]};
            end
          end
        endcase
      end
      if (evt_erase_fail)
        e_erase_ff <= 1'b1;
      if (evt_prog_fail)
        e_prog_ff <= 1'b1;
      if (evt_vpp_bad)
        e_vpp_ff <= 1'b1;
      if (evt_prot_fail)
        e_prot_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### verilog/snf_regs.vh
// snf_regs.vh: opcodes, flag bit positions, reset values and counts for
// the serial flash command decoder. Definitions only; no logic.
// assumes it is included by its bare name from the decoder module.
`ifndef SNF_REGS_VH
`define SNF_REGS_VH
// opcodes
`define SNF_OP_RDFLAG   8'h70
`define SNF_OP_CLRFLAG  8'h50
`define SNF_OP_RDSTAT   8'h05
`define SNF_OP_WRSTAT   8'h01
`define SNF_OP_RDEVC    8'h65
`define SNF_OP_WREVC    8'h61
`define SNF_OP_RDSEG    8'hc8
`define SNF_OP_WRSEG    8'hc5
`define SNF_OP_WREN     8'h06
`define SNF_OP_WRDI     8'h04
`define SNF_OP_ADR4_ON  8'hb7
`define SNF_OP_ADR4_OFF 8'he9
`define SNF_OP_SUSP     8'h75
`define SNF_OP_RESUME   8'h7a
`define SNF_OP_ID_A     8'h9e
`define SNF_OP_ID_B     8'h9f
`define SNF_OP_ID_MIO   8'haf
// operation flag bit positions
`define SNF_FL_READY    7
`define SNF_FL_ESUSP    6
`define SNF_FL_ERASE    5
`define SNF_FL_PROG     4
`define SNF_FL_SUPPLY   3
`define SNF_FL_PSUSP    2
`define SNF_FL_PROT     1
`define SNF_FL_ADR4     0
// reset values
`define SNF_RST_SUPPLY  1'b1
`define SNF_RST_EVC     8'hdf
`define SNF_RST_STAT    8'h00
`define SNF_RST_SEG     1'b0
// evc protocol select bits, active low, and the bit fixed low
`define SNF_EVC_QUAD    7
`define SNF_EVC_DUAL    6
`define SNF_EVC_FIXED0  5
// dummy clock defaults
`define SNF_DMY_DEF     4'h8
`define SNF_DMY_QUAD    4'ha
// byte limits
`define SNF_PROG_MAX    9'h100
`define SNF_ID_EXT_MAX  5'h14
`define SNF_ID_MIO_MAX  5'h03
`endif

// ### dv/snf_cmd_flags_sva.sv
// snf_cmd_flags_sva.sv: port-level checks for the flash command decoder.
// assumes one clock domain, ref_clk, with rst_n synchronous active low.
`timescale 1ns/100ps
`default_nettype none
module snf_cmd_flags_sva (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic [3:0]  dq_in,
  input wire logic [3:0]  dq_out_ff,
  input wire logic [3:0]  dq_oe_ff,
  input wire logic [3:0]  dummy_clks,
  input wire logic        pe_busy,
  input wire logic        erase_susp,
  input wire logic        prog_susp,
  input wire logic        evt_erase_fail,
  input wire logic        evt_prog_fail,
  input wire logic        evt_vpp_bad,
  input wire logic        evt_prot_fail,
  input wire logic [7:0]  arr_rdata,
  input wire logic        arr_rd_stb_ff,
  input wire logic        op_go_ff,
  input wire logic [7:0]  op_code_ff,
  input wire logic [31:0] op_addr_ff,
  input wire logic [7:0]  prog_byte_ff,
  input wire logic        prog_stb_ff,
  input wire logic [7:0]  operation_flags
);
  // single domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // status bits follow their sources once those have settled
  ready_bit_a: assert property (
    $stable(pe_busy) |-> operation_flags[7] == !pe_busy)
    else $error("ready bit does not follow busy");
  erase_susp_a: assert property (
    $stable(erase_susp) |-> operation_flags[6] == erase_susp)
    else $error("erase suspend bit wrong");
  prog_susp_a: assert property (
    $stable(prog_susp) |-> operation_flags[2] == prog_susp)
    else $error("program suspend bit wrong");
  // error events must land in their bit within two cycles
  erase_err_a: assert property (
    evt_erase_fail |-> ##[1:2] operation_flags[5])
    else $error("erase error not flagged");
  prog_err_a: assert property (
    evt_prog_fail |-> ##[1:2] operation_flags[4])
    else $error("program error not flagged");
  supply_err_a: assert property (
    evt_vpp_bad |-> ##[1:2] operation_flags[3])
    else $error("supply error not flagged");
  prot_err_a: assert property (
    evt_prot_fail |-> ##[1:2] operation_flags[1])
    else $error("protection error not flagged");
  // error bits may only drop after a command, i.e. while deselected
  err_hold_a: assert property (
    |($past(operation_flags) & ~operation_flags & 8'h3a) |-> cs_n)
    else $error("error bit dropped inside a frame");
  // operations start only after deselect, as one-cycle pulses
  go_deselect_a: assert property (
    op_go_ff |-> cs_n ##1 !op_go_ff)
    else $error("operation start not a deselect pulse");
  // pending erase, program or protection errors must block every operation start, suspend and resume included; the decoder still starts suspend and resume
  go_blocked_a: assert property (
    op_go_ff |-> ($past(operation_flags) & 8'h32) == 8'h00)
    else $error("operation started with error pending");
  // pins are released shortly after deselect
  oe_release_a: assert property (
    cs_n [*8] |-> dq_oe_ff == 4'h0)
    else $error("data pins driven while deselected");

  go_seen_c: cover property (op_go_ff);
  prog_seen_c: cover property (prog_stb_ff);
  quad_out_c: cover property (dq_oe_ff == 4'hf);
endmodule
bind snf_cmd_flags snf_cmd_flags_sva i_snf_cmd_flags_sva (
  .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
  .dq_in(dq_in), .dq_out_ff(dq_out_ff), .dq_oe_ff(dq_oe_ff),
  .dummy_clks(dummy_clks), .pe_busy(pe_busy), .erase_susp(erase_susp),
  .prog_susp(prog_susp), .evt_erase_fail(evt_erase_fail),
  .evt_prog_fail(evt_prog_fail), .evt_vpp_bad(evt_vpp_bad),
  .evt_prot_fail(evt_prot_fail), .arr_rdata(arr_rdata),
  .arr_rd_stb_ff(arr_rd_stb_ff), .op_go_ff(op_go_ff),
  .op_code_ff(op_code_ff), .op_addr_ff(op_addr_ff),
  .prog_byte_ff(prog_byte_ff), .prog_stb_ff(prog_stb_ff),
  .operation_flags(operation_flags));
`default_nettype wire

// ### dv/snf_host_model.sv
// snf_host_model.sv: serial host for the flash decoder, mode 0, 80 ns sclk.
// assumes ref_clk at 5 ns; tasks are called from the testbench.
`timescale 1ns/100ps
`default_nettype none
module snf_host_model (
  input wire logic        ref_clk,
  output var logic        sclk,
  output var logic        cs_n,
  output logic [3:0]      dq_in,
  input wire logic [3:0]  dq_out_ff,
  input wire logic [3:0]  dq_oe_ff
);
  logic [3:0] h_val;   // value host puts on the lanes
  logic       h_oe;    // host drives the lanes
  logic       quad;    // four lanes instead of one
  logic       oe_seen; // device drove a pin this frame

  // wire level: device wins, else host, else inverted leftover value
  assign dq_in = (dq_oe_ff & dq_out_ff) |
                 (~dq_oe_ff & (h_oe ? h_val : ~h_val));

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    h_oe = 1'b0;
    h_val = 4'h0;
    quad = 1'b0;
    oe_seen = 1'b0;
  end

  // half an sclk period, moves just after a ref_clk edge
  task automatic half;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic start;
    oe_seen = 1'b0;
    cs_n = 1'b0;
    half();
  endtask

  // sclk idles low between frames; long gap lets deselect sync through
  task automatic stop;
    half();
    cs_n = 1'b1;
    h_oe = 1'b0;
    repeat (4) half();
  endtask

  // msb first, quad sends bits 7:4 first
  task automatic tx(input logic [7:0] b);
    int i;
    h_oe = 1'b1;
    for (i = 0; i < (quad ? 2 : 8); i++) begin
      h_val = quad ? b[7-4*i -: 4] : {3'h0, b[7-i]};
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
  endtask

  // device shifts on the fall, host samples on the next rise
  task automatic rx(output logic [7:0] b);
    int i;
    h_oe = 1'b0;
    b = 8'h00;
    for (i = 0; i < (quad ? 2 : 8); i++) begin
      half();
      sclk = 1'b1;
      oe_seen = oe_seen | (|dq_oe_ff);
      b = quad ? {b[3:0], dq_in} : {b[6:0], dq_in[1]};
      half();
      sclk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ### dv/tb_snf_cmd_flags.sv
// tb_snf_cmd_flags.sv: self-checking bench for the flash command decoder.
// assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
module tb_snf_cmd_flags;
  logic        ref_clk, rst_n, sclk, cs_n, pe_busy, erase_susp, prog_susp;
  logic        evt_erase_fail, evt_prog_fail, evt_vpp_bad, evt_prot_fail;
  logic        arr_rd_stb_ff, op_go_ff, prog_stb_ff;
  wire  [3:0]  dq_in;
  logic [3:0]  dq_out_ff, dq_oe_ff, dummy_clks;
  logic [7:0]  arr_rdata, op_code_ff, prog_byte_ff, operation_flags, b;
  logic [31:0] op_addr_ff;
  logic [7:0]  bad [4] = '{8'h9f, 8'h3b, 8'h3d, 8'ha2}; // quad refusals
  int          miscompares, checks_done, go_cnt, stb_cnt, rd_cnt, k;

  snf_cmd_flags #(.ID_BYTES(24'h5a3c11)) i_snf_cmd_flags (
    .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
    .dq_in(dq_in), .dq_out_ff(dq_out_ff), .dq_oe_ff(dq_oe_ff),
    .dummy_clks(dummy_clks), .pe_busy(pe_busy), .erase_susp(erase_susp),
    .prog_susp(prog_susp), .evt_erase_fail(evt_erase_fail),
    .evt_prog_fail(evt_prog_fail), .evt_vpp_bad(evt_vpp_bad),
    .evt_prot_fail(evt_prot_fail), .arr_rdata(arr_rdata),
    .arr_rd_stb_ff(arr_rd_stb_ff), .op_go_ff(op_go_ff),
    .op_code_ff(op_code_ff), .op_addr_ff(op_addr_ff),
    .prog_byte_ff(prog_byte_ff), .prog_stb_ff(prog_stb_ff),
    .operation_flags(operation_flags));

  snf_host_model i_snf_host_model (
    .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
    .dq_out_ff(dq_out_ff), .dq_oe_ff(dq_oe_ff));

  // 200 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // count operation starts and program bytes as they pulse
  always @(posedge ref_clk) begin
    if (op_go_ff === 1'b1) go_cnt++;
    if (prog_stb_ff === 1'b1) stb_cnt++;
    if (arr_rd_stb_ff === 1'b1) rd_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one frame: opcode then n bytes taken from the top of d
  task automatic frm(input logic [7:0] op, input logic [39:0] d,
                     input int n);
    int i;
    i_snf_host_model.start();
    i_snf_host_model.tx(op);
    for (i = 0; i < n; i++) i_snf_host_model.tx(d[39-8*i -: 8]);
    i_snf_host_model.stop();
  endtask

  // register read: two bytes, both must match since output repeats
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    i_snf_host_model.start();
    i_snf_host_model.tx(op);
    i_snf_host_model.rx(b);
    chk({24'h0, b}, {24'h0, exp});
    i_snf_host_model.rx(b);
    chk({24'h0, b}, {24'h0, exp});
    i_snf_host_model.stop();
  endtask

  task automatic we;
    frm(8'h06, 40'h0, 0);
  endtask

  // watchdog: the sequence needs roughly 56 us
  initial begin
    #400000;
    miscompares++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    {pe_busy, erase_susp, prog_susp} = 3'h0;
    {evt_erase_fail, evt_prog_fail, evt_vpp_bad, evt_prot_fail} = 4'h0;
    dummy_clks = 4'h0;
    arr_rdata = 8'h00;
    repeat (3) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge ref_clk);
    chk({24'h0, operation_flags}, 32'h88);
    rd(8'h70, 8'h88);
    // status bits follow the array state with no command
    {pe_busy, erase_susp, prog_susp} = 3'h7;
    rd(8'h70, 8'h4c);
    {pe_busy, erase_susp, prog_susp} = 3'h0;
    rd(8'h70, 8'h88);
    frm(8'h50, 40'h0, 0);
    rd(8'h70, 8'h80);
    // raise every error at once, then try an erase
    @(posedge ref_clk);
    #1;
    {evt_erase_fail, evt_prog_fail, evt_vpp_bad, evt_prot_fail} = 4'hf;
    @(posedge ref_clk);
    #1;
    {evt_erase_fail, evt_prog_fail, evt_vpp_bad, evt_prot_fail} = 4'h0;
    rd(8'h70, 8'hba);
    we();
    frm(8'h20, 40'h0123450000, 3);
    chk(go_cnt, 0);
    rd(8'h70, 8'hba);
    frm(8'h50, 40'h0, 0);
    rd(8'h70, 8'h80);
    // erase refused without write enable, taken with it
    frm(8'h20, 40'h0123450000, 3);
    chk(go_cnt, 0);
    we();
    frm(8'h20, 40'h0123450000, 3);
    chk(go_cnt, 1);
    chk({24'h0, op_code_ff}, 32'h20);
    chk(op_addr_ff, 32'h00012345);
    we();
    frm(8'h02, 40'h000100a53c, 5);
    chk(go_cnt, 2);
    chk({24'h0, op_code_ff}, 32'h02);
    chk(stb_cnt, 2);
    chk({24'h0, prog_byte_ff}, 32'h3c);
    we();
    frm(8'h01, 40'hfc00000000, 1);
    rd(8'h05, 8'hfc);
    we();
    frm(8'hc5, 40'h0100000000, 1);
    rd(8'hc8, 8'h01);
    // fast read: three address bytes, one byte of clocks as dummies
    arr_rdata = 8'h96;
    i_snf_host_model.start();
    i_snf_host_model.tx(8'h0b);
    for (k = 0; k < 4; k++) i_snf_host_model.tx(8'h00);
    i_snf_host_model.rx(b);
    i_snf_host_model.stop();
    chk({24'h0, b}, 32'h96);
    chk(rd_cnt, 2);
    we();
    frm(8'hb7, 40'h0, 0);
    rd(8'h70, 8'h81);
    // move to quad protocol and repeat reads there
    we();
    frm(8'h61, 40'h5f00000000, 1);
    i_snf_host_model.quad = 1'b1;
    rd(8'h65, 8'h5f);
    rd(8'h70, 8'h81);
    for (k = 0; k < 4; k++) begin
      i_snf_host_model.start();
      i_snf_host_model.tx(bad[k]);
      i_snf_host_model.rx(b);
      i_snf_host_model.stop();
      chk({31'h0, i_snf_host_model.oe_seen}, 32'h0);
    end
    i_snf_host_model.start();
    i_snf_host_model.tx(8'haf);
    i_snf_host_model.rx(b);
    chk({24'h0, b}, 32'h5a);
    i_snf_host_model.rx(b);
    chk({24'h0, b}, 32'h3c);
    i_snf_host_model.rx(b);
    chk({24'h0, b}, 32'h11);
    i_snf_host_model.rx(b);
    chk({24'h0, b}, 32'h00);
    i_snf_host_model.stop();
    summarize();
  end
endmodule
`default_nettype wire
